// ---- rtl/hsi_consts.svh ----
`ifndef HSI_CONSTS_SVH
`define HSI_CONSTS_SVH

// ----------------------------------------
// timing, clock and figures
// ----------------------------------------
`define HSI_CLK_HZ 20000000
`define HSI_MIN_PULSE_NS 50000
`define HSI_HOLD_NS 512000
// least time rounds up
`define HSI_MIN_PULSE_CYC ((`HSI_MIN_PULSE_NS * (`HSI_CLK_HZ / 1000000) + 999) / 1000)
`define HSI_HOLD_CYC ((`HSI_HOLD_NS * (`HSI_CLK_HZ / 1000000) + 999) / 1000)

// ----------------------------------------
// relay numbering and defaults
// ----------------------------------------
`define HSI_N_POINTS 4
`define HSI_CAP_FIRST_RELAY 17
`define HSI_INT_FIRST_RELAY 1
`define HSI_RELAY_W 5
`define HSI_MODE_CAPTURE 1'b0
`define HSI_MODE_INTERRUPT 1'b1

`endif

// ---- rtl/hsi_input.sv ----
`timescale 1ns/1ps
`include "hsi_consts.svh"

module hsi_input #(
	parameter int N_POINTS = `HSI_N_POINTS,
	parameter int MIN_PULSE_CYC = `HSI_MIN_PULSE_CYC,
	parameter int HOLD_CYC = `HSI_HOLD_CYC
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic mode_sel,
	input wire logic [N_POINTS-1:0] field_in,
	input wire logic refresh_rd,
	output logic [N_POINTS-1:0] relay_q,
	output logic int_mode_q,
	output hsi_pkg::hsi_relay_t first_relay_q,
	output logic [N_POINTS-1:0] irq_q
);
	import hsi_pkg::*;

	localparam int CW = $clog2(HOLD_CYC + 1);

	// ----------------------------------------
	// mode selection and relay base
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			int_mode_q <= `HSI_MODE_CAPTURE;
		end else begin
			int_mode_q <= mode_sel;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			first_relay_q <= hsi_relay_t'(`HSI_CAP_FIRST_RELAY);
		end else if (int_mode_q == `HSI_MODE_INTERRUPT) begin
			first_relay_q <= hsi_relay_t'(`HSI_INT_FIRST_RELAY);
		end else begin
			first_relay_q <= hsi_relay_t'(`HSI_CAP_FIRST_RELAY);
		end
	end

	// ----------------------------------------
	// per-point conditioning
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < N_POINTS; g++) begin : g_pt
			logic s1_q;
			logic s2_q;
			logic prev_q;
			logic [CW-1:0] wid_q;
			logic [CW-1:0] hold_q;
			logic caught_q;
			logic seen_q;
			hsi_int_state_t st_q;
			logic qual;
			logic rise;

			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					s1_q <= 1'b0;
					s2_q <= 1'b0;
					prev_q <= 1'b0;
				end else begin
					s1_q <= field_in[g];
					s2_q <= s1_q;
					prev_q <= s2_q;
				end
			end

			// ----------------------------------------
			// pulse width qualification
			// ----------------------------------------
			// width counter saturates so long pulses do not wrap
			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					wid_q <= '0;
				end else if (!s2_q) begin
					wid_q <= '0;
				end else if (wid_q < CW'(MIN_PULSE_CYC)) begin
					wid_q <= wid_q + CW'(1);
				end
			end

			assign qual = s2_q && (wid_q == CW'(MIN_PULSE_CYC - 1));

			// ----------------------------------------
			// capture latch
			// ----------------------------------------
			// set wins over a refresh in the same cycle, so no pulse is lost
			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					caught_q <= 1'b0;
				end else if (int_mode_q) begin
					caught_q <= 1'b0;
				end else if (qual && !seen_q) begin
					caught_q <= 1'b1;
				end else if (refresh_rd) begin
					caught_q <= 1'b0;
				end
			end

			// one catch per high level, so a long level shows for one scan only
			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					seen_q <= 1'b0;
				end else if (int_mode_q) begin
					seen_q <= 1'b0;
				end else if (!s2_q) begin
					seen_q <= 1'b0;
				end else if (qual) begin
					seen_q <= 1'b1;
				end
			end

			// ----------------------------------------
			// interrupt hold
			// ----------------------------------------
			assign rise = s2_q && !prev_q;

			// retrigger only after input returns low, so a held level cannot refire
			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					st_q <= HSI_IDLE;
				end else if (!int_mode_q) begin
					st_q <= HSI_IDLE;
				end else begin
					case (st_q)
						HSI_IDLE: begin
							if (rise) begin
								st_q <= HSI_HOLD;
							end
						end
						HSI_HOLD: begin
							if (hold_q == '0) begin
								st_q <= HSI_WAIT_LOW;
							end
						end
						HSI_WAIT_LOW: begin
							if (!s2_q) begin
								st_q <= HSI_IDLE;
							end
						end
						default: begin
							st_q <= HSI_IDLE;
						end
					endcase
				end
			end

			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					hold_q <= '0;
				end else if (!int_mode_q) begin
					hold_q <= '0;
				end else if ((st_q == HSI_IDLE) && rise) begin
					hold_q <= CW'(HOLD_CYC - 1);
				end else if ((st_q == HSI_HOLD) && (hold_q != '0)) begin
					hold_q <= hold_q - CW'(1);
				end
			end

			// ----------------------------------------
			// reported outputs
			// ----------------------------------------
			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					relay_q[g] <= 1'b0;
				end else if (int_mode_q) begin
					relay_q[g] <= (st_q == HSI_HOLD);
				end else begin
					relay_q[g] <= caught_q;
				end
			end

			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					irq_q[g] <= 1'b0;
				end else if (int_mode_q) begin
					irq_q[g] <= (st_q == HSI_IDLE) && rise;
				end else begin
					irq_q[g] <= 1'b0;
				end
			end
		end
	endgenerate
endmodule : hsi_input

// ---- rtl/hsi_pkg.sv ----
package hsi_pkg;
	typedef enum logic [2:0] {
		HSI_IDLE = 3'b001,
		HSI_HOLD = 3'b010,
		HSI_WAIT_LOW = 3'b100
	} hsi_int_state_t;
	typedef logic [4:0] hsi_relay_t;
endpackage : hsi_pkg

// ---- test/hsi_cpu_model.sv ----
`timescale 1ns/1ps
// single cpu reading; refresh follows the request one cycle late
module hsi_cpu_model (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic rd_req,
	output logic refresh_rd
);
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) refresh_rd <= 1'b0;
		else refresh_rd <= rd_req;
	end
endmodule : hsi_cpu_model

// ---- test/hsi_input_asserts.sv ----
`timescale 1ns/1ps
module hsi_input_asserts (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic mode_sel,
	input wire logic [3:0] field_in,
	input wire logic refresh_rd,
	input wire logic [3:0] relay_q,
	input wire logic int_mode_q,
	input wire hsi_pkg::hsi_relay_t first_relay_q,
	input wire logic [3:0] irq_q
);
	import hsi_pkg::*;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	AST_BASE: assert property (first_relay_q == ($past(int_mode_q) ? 5'h01 : 5'h11)) else $error("bad base");
	AST_IRQREL: assert property (irq_q[0] |=> relay_q[0]) else $error("irq without hold");
	AST_NOREIRQ: assert property (irq_q[0] |=> !irq_q[0] [*8]) else $error("retrigger");
	AST_IRQCAP: assert property (irq_q != 4'h0 |-> int_mode_q) else $error("irq in capture");
	AST_HOLD: assert property (int_mode_q && $rose(relay_q[1]) |-> relay_q[1] [*8]) else $error("short hold");
	AST_CAPHOLD: assert property (!mode_sel && !int_mode_q && relay_q[0] && !refresh_rd && !$past(refresh_rd)
		&& !$past(refresh_rd, 2) |=> relay_q[0]) else $error("catch lost");
	AST_CAPRISE: assert property (!int_mode_q && $rose(relay_q[0]) |-> $past(field_in[0], 3)) else $error("no pulse");
	AST_CAPONE: assert property (!int_mode_q && $fell(relay_q[0]) |=> !relay_q[0] [*3]) else $error("recaught");
endmodule : hsi_input_asserts
bind hsi_input hsi_input_asserts i_chk (.*);

// ---- test/hsi_input_tb.sv ----
`timescale 1ns/1ps
module hsi_input_tb;
	import hsi_pkg::*;
	logic sys_clk = 0, rst_n = 0, mode_sel = 0, rd_req = 0, refresh_rd, int_mode_q;
	logic [3:0] field_in = 0, relay_q, irq_q;
	hsi_relay_t first_relay_q;
	int fails = 0, cmp_count = 0, len;
	hsi_input #(.MIN_PULSE_CYC(4), .HOLD_CYC(16)) i_dut (.*);
	hsi_cpu_model i_cpu (.*);
	initial forever #25 sys_clk = ~sys_clk;
	task cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : cyc
	task chk(input string nm, input logic [4:0] e, input logic [4:0] s);
		cmp_count++;
		if (s !== e) begin
			fails++;
			$display("[FAIL] %s exp %h got %h", nm, e, s);
		end
	endtask : chk
	task end_sim;
		$display("checks %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : end_sim
	task refresh;
		rd_req = 1;
		cyc(1);
		rd_req = 0;
		cyc(4);
	endtask : refresh
	initial begin
		#200us;
		fails++;
		end_sim;
	end
	initial begin
		void'($urandom(32'hd27eacc7));
		cyc(8);
		rst_n = 1;
		cyc(2);
		chk("base", 5'h11, first_relay_q);
		chk("mode", 5'h00, {4'h0, int_mode_q});
		field_in[1] = 1;
		cyc(2);
		field_in[1] = 0;
		cyc(8);
		chk("short", 5'h00, {1'b0, relay_q});
		for (int p = 0; p < 4; p++) begin
			len = 4 + $urandom % 6;
			field_in[p] = 1;
			cyc(len);
			field_in[p] = 0;
			cyc(6 + $urandom % 20);
			chk("caught", 5'(1 << p), {1'b0, relay_q});
			refresh;
			chk("cleared", 5'h00, {1'b0, relay_q});
		end
		field_in[0] = 1;
		cyc(12);
		refresh;
		chk("long", 5'h00, {1'b0, relay_q});
		chk("noirq", 5'h00, {1'b0, irq_q});
		field_in[0] = 0;
		$display("capture test done");
		mode_sel = 1;
		cyc(4);
		chk("base", 5'h01, first_relay_q);
		chk("mode", 5'h01, {4'h0, int_mode_q});
		// all four points, one at a time, spaced well apart
		for (int p = 0; p < 4; p++) begin
			field_in[p] = 1;
			cyc(3);
			chk("irq", 5'(1 << p), {1'b0, irq_q});
			field_in[p] = 0;
			cyc(2);
			field_in[p] = 1;
			cyc(8 + $urandom % 4);
			chk("held", 5'(1 << p), {1'b0, relay_q});
			chk("blocked", 5'h00, {1'b0, irq_q});
			field_in[p] = 0;
			cyc(12);
			chk("released", 5'h00, {1'b0, relay_q});
		end
		$display("interrupt test done");
		end_sim;
	end
endmodule : hsi_input_tb
